//--- core/adcsc_top.sv
// converter sequencing control: AXI4-Lite registers, trigger, successive approximation sequencer
//
// Contract
// - eight-bit read-only result register holds the last completed conversion.
// - result readable any time; value during a conversion is not guaranteed.
// - completed result stays unchanged until another conversion begins.
// - reset does not touch the result register.
// - mode register resets to 0x30.
// - mode bit 7 picks 62 clocks (0) or 31 clocks (1) per conversion.
// - mode bit 6 lets the selected trigger pin edge start a conversion.
// - mode bits 5 and 4 read as one and ignore writes.
// - channel field: 00xx none, 01xx inputs 0-3, 10xx 4-7, 11xx 8-11.
// - start register bits 6..0 read as one; start flag resets to 0.
// - start flag write of 1 or enabled trigger edge starts; edge sets flag.
// - at completion result loads and start flag clears in the same cycle.
// - writing 0 to the start flag aborts; flag shows conversion running.
// - successive approximation, eight bits, one bit per step, msb first.
// - flag falling sets done request; interrupt only when its enable is set.
// - trigger pin acts only when pin function select and trigger enable set.
// - selected edge polarity on the enabled pin sets the flag and starts.
// - start register resets to 0x7f.
`timescale 1ns/1ps

module adcsc_top
  import adcsc_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    rst,
  // axi4-lite write address
  input  wire logic [ADCSC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADCSC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // analog side
  output adcsc_ana_type                ana,
  input  wire logic                    comparator_high,
  // trigger and interrupt
  input  wire logic                    conversion_trigger_pin,
  output logic                         conversion_done_irq
);

  typedef enum logic [1:0] {ADCSC_IDLE, ADCSC_SAMPLE, ADCSC_STEP} adcsc_state_type;

  // input select: enable plus index 0..11
  function automatic logic [4:0] adcsc_chan_decode(input logic [3:0] ch);
    logic [3:0] idx;
    idx = ch - 4'h4;
    return {(ch[3] | ch[2]), idx};
  endfunction : adcsc_chan_decode

  // full word address: a misaligned byte address matches nothing and is refused
  function automatic logic adcsc_hit(input logic [ADCSC_ADDR_W-1:0] a, input logic [3:0] off);
    return a == off;
  endfunction : adcsc_hit

  // one-hot mask of the bit under trial
  function automatic logic [7:0] adcsc_bit_mask(input logic [2:0] b);
    return 8'h01 << b;
  endfunction : adcsc_bit_mask

  // registers
  adcsc_mode_type              mode_q;
  logic                        busy_q;
  logic [7:0]                  result_q;
  logic                        done_req_q;
  logic                        done_en_q;
  logic                        pin_fn_q;
  logic                        edge_rise_q;
  adcsc_state_type             state_q;
  logic [5:0]                  cnt_q;
  logic [2:0]                  bit_q;
  logic [7:0]                  trial_q;
  logic                        trig_prev_q;
  logic                        trig_armed_q;

  // bus slave state
  logic                        aw_held_q;
  logic [ADCSC_ADDR_W-1:0]     aw_addr_q;
  logic                        w_held_q;
  logic [7:0]                  w_data_q;
  logic                        w_lane0_q;

  // ---------------- bus write path ----------------
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  // a response still waiting for bready holds the next write back
  wire       wr_fire  = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire       wa_mode  = adcsc_hit(aw_addr_q, ADCSC_OFF_MODE);
  wire       wa_start = adcsc_hit(aw_addr_q, ADCSC_OFF_START);
  wire       wa_res   = adcsc_hit(aw_addr_q, ADCSC_OFF_RESULT);
  wire       wa_irq   = adcsc_hit(aw_addr_q, ADCSC_OFF_IRQ);
  wire       wr_known = wa_mode | wa_start | wa_res | wa_irq;
  // a cleared byte-0 strobe turns the write into a no-op that still answers
  wire       wr_lane  = wr_fire & w_lane0_q;
  wire       wr_mode  = wr_lane & wa_mode;
  wire       wr_start = wr_lane & wa_start;
  wire       wr_irq   = wr_lane & wa_irq;
  wire [1:0] wr_resp  = wr_known ? ADCSC_RESP_OKAY : ADCSC_RESP_SLVERR;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_data_q      <= 8'h00;
      w_lane0_q     <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ADCSC_RESP_OKAY;
    end else begin
      // readies drop after a take so a held channel is never overwritten
      s_axi_awready <= ~aw_held_q & ~aw_take;
      s_axi_wready  <= ~w_held_q & ~w_take;
      if (aw_take) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q  <= 1'b1;
        w_data_q  <= s_axi_wdata[7:0];
        w_lane0_q <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wr_resp;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ---------------- bus read path ----------------
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [7:0] rd_mode  = mode_q | ADCSC_MODE_RSV_ONES;
  wire [7:0] rd_start = {busy_q, ADCSC_START_RSV[6:0]};
  wire [7:0] rd_irq   = {4'h0, edge_rise_q, pin_fn_q, done_en_q, done_req_q};
  wire rd_m = adcsc_hit(s_axi_araddr, ADCSC_OFF_MODE);
  wire rd_s = adcsc_hit(s_axi_araddr, ADCSC_OFF_START);
  wire rd_r = adcsc_hit(s_axi_araddr, ADCSC_OFF_RESULT);
  wire rd_i = adcsc_hit(s_axi_araddr, ADCSC_OFF_IRQ);
  // result is readable at any moment; mid-conversion it shows the previous value
  wire [7:0] rd_byte = rd_m ? rd_mode  :
                       rd_s ? rd_start :
                       rd_r ? result_q :
                       rd_i ? rd_irq   :
                       8'h00;
  wire       rd_ok   = rd_m | rd_s | rd_r | rd_i;
  wire [1:0] rd_resp = rd_ok ? ADCSC_RESP_OKAY : ADCSC_RESP_SLVERR;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ADCSC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_resp;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------- trigger edge ----------------
  // armed bit keeps a pin already high at reset release from looking like an edge
  wire trig_rise  = conversion_trigger_pin & ~trig_prev_q;
  wire trig_fall  = ~conversion_trigger_pin & trig_prev_q;
  wire trig_gate  = pin_fn_q & mode_q.trig_en;
  wire trig_edge  = edge_rise_q ? trig_rise : trig_fall;
  wire trig_event = trig_armed_q & trig_gate & trig_edge;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trig_prev_q  <= 1'b0;
      trig_armed_q <= 1'b0;
    end else begin
      trig_prev_q  <= conversion_trigger_pin;
      trig_armed_q <= 1'b1;
    end
  end

  // ---------------- sequencer ----------------
  wire       wr_flag     = w_data_q[ADCSC_START_FLAG_BIT];
  wire       sw_start    = wr_start & wr_flag;
  wire       sw_abort    = wr_start & ~wr_flag;
  // a start while running is dropped, so the live conversion is never restarted
  wire       go          = ~busy_q & ~sw_abort & (sw_start | trig_event);
  wire [5:0] sample_len  = mode_q.speed ? ADCSC_FAST_SAMPLE : ADCSC_SLOW_SAMPLE;
  wire [5:0] step_len    = mode_q.speed ? ADCSC_FAST_STEP : ADCSC_SLOW_STEP;
  wire [5:0] sample_load = sample_len - 6'd1;
  wire [5:0] step_load   = step_len - 6'd1;
  wire       cnt_zero    = (cnt_q == 6'd0);
  wire [2:0] bit_next    = bit_q - 3'd1;
  wire       in_sample   = (state_q == ADCSC_SAMPLE);
  wire       step_end    = (state_q == ADCSC_STEP) & cnt_zero;
  // comparator low: the trial code overshoots the input, so the bit under trial drops
  wire [7:0] decided     = comparator_high ? trial_q : (trial_q & ~adcsc_bit_mask(bit_q));
  wire       finish      = busy_q & step_end & (bit_q == 3'd0) & ~sw_abort;
  wire       flag_fall   = busy_q & (finish | sw_abort);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ADCSC_IDLE;
      busy_q  <= ADCSC_START_RST[ADCSC_START_FLAG_BIT];
      cnt_q   <= 6'd0;
      bit_q   <= 3'd7;
      trial_q <= 8'h00;
    end else if (sw_abort) begin
      // abort drops to idle at once and loads no result
      state_q <= ADCSC_IDLE;
      busy_q  <= 1'b0;
    end else begin
      case (state_q)
        ADCSC_IDLE: begin
          if (go) begin
            state_q <= ADCSC_SAMPLE;
            busy_q  <= 1'b1;
            cnt_q   <= sample_load;
            bit_q   <= 3'd7;
            trial_q <= 8'h80;
          end
        end
        ADCSC_SAMPLE: begin
          if (cnt_zero) begin
            state_q <= ADCSC_STEP;
            cnt_q   <= step_load;
          end else begin
            cnt_q <= cnt_q - 6'd1;
          end
        end
        ADCSC_STEP: begin
          if (!cnt_zero) begin
            cnt_q <= cnt_q - 6'd1;
          end else if (bit_q == 3'd0) begin
            state_q <= ADCSC_IDLE;
            busy_q  <= 1'b0;
            trial_q <= decided;
          end else begin
            trial_q <= decided | adcsc_bit_mask(bit_next);
            bit_q   <= bit_next;
            cnt_q   <= step_load;
          end
        end
        // unused encoding falls back to idle
        default: begin
          state_q <= ADCSC_IDLE;
          busy_q  <= 1'b0;
        end
      endcase
    end
  end

  // result has no reset; it changes only on completion
  always_ff @(posedge sys_clk) begin
    if (finish) begin
      result_q <= decided;
    end
  end

  // ---------------- mode and request/enable registers ----------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode_q      <= ADCSC_MODE_RST;
      done_req_q  <= 1'b0;
      done_en_q   <= 1'b0;
      pin_fn_q    <= 1'b0;
      edge_rise_q <= 1'b0;
    end else begin
      // reserved bits are never written, so they keep their reset ones
      if (wr_mode) begin
        mode_q.speed   <= w_data_q[ADCSC_MODE_SPEED_BIT];
        mode_q.trig_en <= w_data_q[ADCSC_MODE_TRIG_BIT];
        mode_q.chan    <= w_data_q[ADCSC_MODE_CHAN_LSB +: ADCSC_MODE_CHAN_W];
      end
      if (wr_irq) begin
        done_en_q   <= w_data_q[ADCSC_IRQ_EN_BIT];
        pin_fn_q    <= w_data_q[ADCSC_IRQ_PINFN_BIT];
        edge_rise_q <= w_data_q[ADCSC_IRQ_EDGE_BIT];
      end
      // writing 0 clears the request; a flag fall in the same cycle wins
      if (flag_fall) begin
        done_req_q <= 1'b1;
      end else if (wr_irq & ~w_data_q[ADCSC_IRQ_REQ_BIT]) begin
        done_req_q <= 1'b0;
      end
    end
  end

  // ---------------- registered outputs ----------------
  wire [4:0] chan_dec = adcsc_chan_decode(mode_q.chan);
  wire       chan_on  = chan_dec[4];
  wire [3:0] chan_idx = chan_dec[3:0];
  // request and enable meet a cycle late so the pin comes straight from a flop
  wire       irq_d    = done_req_q & done_en_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ana                 <= '0;
      conversion_done_irq <= 1'b0;
    end else begin
      ana.mux_en          <= chan_on;
      ana.mux_sel         <= chan_idx;
      ana.sample          <= in_sample;
      ana.trial           <= trial_q;
      conversion_done_irq <= irq_d;
    end
  end

endmodule : adcsc_top

//--- core/adcsc_pkg.sv
// package: register map, field layout, reset values and timing of the converter control
package adcsc_pkg;

  // register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] ADCSC_OFF_MODE   = 4'h0;
  localparam logic [3:0] ADCSC_OFF_START  = 4'h4;
  localparam logic [3:0] ADCSC_OFF_RESULT = 4'h8;
  localparam logic [3:0] ADCSC_OFF_IRQ    = 4'hc;
  localparam int         ADCSC_ADDR_W     = 4;

  // converter_mode_reg field positions
  localparam int ADCSC_MODE_SPEED_BIT = 7;
  localparam int ADCSC_MODE_TRIG_BIT  = 6;
  localparam int ADCSC_MODE_CHAN_LSB  = 0;
  localparam int ADCSC_MODE_CHAN_W    = 4;
  // conversion_start_reg field position
  localparam int ADCSC_START_FLAG_BIT = 7;
  // irq/pin control register field positions
  localparam int ADCSC_IRQ_REQ_BIT    = 0;
  localparam int ADCSC_IRQ_EN_BIT     = 1;
  localparam int ADCSC_IRQ_PINFN_BIT  = 2;
  localparam int ADCSC_IRQ_EDGE_BIT   = 3;

  // reset values and read-as-one masks
  localparam logic [7:0] ADCSC_MODE_RST      = 8'h30;
  localparam logic [7:0] ADCSC_MODE_RSV_ONES = 8'h30;
  localparam logic [7:0] ADCSC_START_RST     = 8'h7f;
  localparam logic [7:0] ADCSC_START_RSV     = 8'h7f;

  // conversion timing in system clocks: sample phase plus eight equal steps
  localparam int         ADCSC_SLOW_TOTAL  = 62;
  localparam int         ADCSC_FAST_TOTAL  = 31;
  localparam logic [5:0] ADCSC_SLOW_SAMPLE = 6'd14;
  localparam logic [5:0] ADCSC_SLOW_STEP   = 6'((ADCSC_SLOW_TOTAL - 14) / 8);
  localparam logic [5:0] ADCSC_FAST_SAMPLE = 6'd7;
  localparam logic [5:0] ADCSC_FAST_STEP   = 6'((ADCSC_FAST_TOTAL - 7) / 8);

  // axi responses
  localparam logic [1:0] ADCSC_RESP_OKAY   = 2'b00;
  localparam logic [1:0] ADCSC_RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic       speed;
    logic       trig_en;
    logic [1:0] rsv;
    logic [3:0] chan;
  } adcsc_mode_type;

  // drive toward the analog ladder, comparator and input multiplexer
  typedef struct packed {
    logic       mux_en;
    logic [3:0] mux_sel;
    logic       sample;
    logic [7:0] trial;
  } adcsc_ana_type;

endpackage : adcsc_pkg

//--- dv/adcsc_sva.sv
// checker: port-level properties of the converter control
`timescale 1ns/1ps
module adcsc_sva
  import adcsc_pkg::*;
(
  // clock and reset
  input wire logic          sys_clk,
  input wire logic          rst,
  // register bus
  input wire logic [3:0]    s_axi_awaddr,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic [31:0]   s_axi_wdata,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [3:0]    s_axi_araddr,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_rvalid,
  // converter side
  input wire adcsc_ana_type ana,
  input wire logic          conversion_done_irq
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_rd_take(logic [3:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  sequence s_irq_off;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
    s_axi_awaddr == ADCSC_OFF_IRQ && !s_axi_wdata[ADCSC_IRQ_EN_BIT];
  endsequence
  a_sample_trial_msb: assert property ($rose(ana.sample) |-> ana.trial == 8'h80)
    else $error("trial not midscale at sample start");
  a_sample_trial_hold: assert property (ana.sample && $past(ana.sample) |-> $stable(ana.trial))
    else $error("trial moved while sampling");
  a_sample_min_len: assert property ($rose(ana.sample) |-> ana.sample [*7])
    else $error("sample phase too short");
  a_mux_sel_range: assert property (ana.mux_en |-> ana.mux_sel <= 4'd11)
    else $error("input select out of range");
  a_mode_rsv_ones: assert property (s_rd_take(ADCSC_OFF_MODE) |=> s_axi_rvalid && s_axi_rdata[5:4] == 2'b11)
    else $error("mode reserved bits not one");
  a_start_rsv_ones: assert property (s_rd_take(ADCSC_OFF_START) |=> s_axi_rvalid && s_axi_rdata[6:0] == 7'h7f)
    else $error("start reserved bits not one");
  a_result_width: assert property (s_rd_take(ADCSC_OFF_RESULT) |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("result wider than eight bits");
  a_irq_enable_off: assert property (s_irq_off |=> ##2 !conversion_done_irq)
    else $error("irq high with enable cleared");
endmodule : adcsc_sva

bind adcsc_top adcsc_sva u_sva (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .ana, .conversion_done_irq);

//--- dv/adcsc_ana_model.sv
// analog side model: input multiplexer with fixed levels and a comparator
`timescale 1ns/1ps
module adcsc_ana_model
  import adcsc_pkg::*;
(
  // clock and converter drive
  input wire logic          sys_clk,
  input wire adcsc_ana_type ana,
  // input levels, settling mode, reply
  input wire logic [7:0]    level [12],
  input wire logic          slow,
  output logic              comparator_high
);
  logic cmp_now;
  logic cmp_q;
  logic float_q = 1'b0;
  // nothing selected: node floats, so it flips every cycle
  assign cmp_now = ana.mux_en ? (level[ana.mux_sel] >= ana.trial) : float_q;
  always @(posedge sys_clk) begin
    float_q <= ~float_q;
    cmp_q <= cmp_now;
  end
  // slow settling answers a cycle late, still inside one step
  assign comparator_high = slow ? cmp_q : cmp_now;
endmodule : adcsc_ana_model

//--- dv/adcsc_tb_top.sv
// testbench: register bus tasks and scenarios for the converter control
`timescale 1ns/1ps
module adcsc_tb_top;
  import adcsc_pkg::*;
  logic          sys_clk = 1'b0;
  logic          rst = 1'b1;
  logic [3:0]    awaddr = 4'h0;
  logic [3:0]    araddr = 4'h0;
  logic [31:0]   wdata = 32'h0;
  logic          awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic          arvalid = 1'b0, rready = 1'b0, pin = 1'b0, slow = 1'b0;
  logic          awready, wready, bvalid, arready, rvalid, cmp, irq;
  logic [1:0]    bresp, rresp;
  logic [31:0]   rdata;
  adcsc_ana_type ana;
  logic [7:0]    level [12];
  logic [4:0]    tcase [5] = '{5'b10110, 5'b01110, 5'b11111, 5'b11010, 5'b11001};
  logic [4:0]    tc;
  int            cmp_count = 0;
  int            fail_count = 0;
  time           t0;

  always #4 sys_clk = ~sys_clk;

  adcsc_top DUT (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ana(ana), .comparator_high(cmp), .conversion_trigger_pin(pin),
    .conversion_done_irq(irq));
  adcsc_ana_model u_ana (.sys_clk(sys_clk), .ana(ana), .level(level), .slow(slow), .comparator_high(cmp));

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er = ADCSC_RESP_OKAY);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rc(input logic [3:0] a, input logic [7:0] e, input logic [1:0] er = ADCSC_RESP_OKAY);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h0, e});
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rc

  // edges from start acknowledge until the irq is seen; irq lags the flag by one
  task automatic wait_done(input int n);
    do @(posedge sys_clk); while (irq !== 1'b1);
    chk(32'((($time - t0) / 8)), 32'(n));
  endtask : wait_done

  initial begin
    for (int i = 0; i < 12; i++) level[i] = 8'(i * 23 + 1);
    level[0] = 8'h00;
    level[11] = 8'hff;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rc(ADCSC_OFF_MODE, 8'h30);
    rc(ADCSC_OFF_START, 8'h7f);
    rc(ADCSC_OFF_IRQ, 8'h00);
    rc(4'h1, 8'h00, ADCSC_RESP_SLVERR);
    wr(4'h1, 8'hff, ADCSC_RESP_SLVERR);
    wr(ADCSC_OFF_MODE, 8'h03);
    rc(ADCSC_OFF_MODE, 8'h33);
    chk({31'h0, ana.mux_en}, 32'h0);
    wr(ADCSC_OFF_START, 8'h00);
    rc(ADCSC_OFF_START, 8'h7f);
    wr(ADCSC_OFF_RESULT, 8'h55);
    wr(ADCSC_OFF_IRQ, 8'h02);
    for (int i = 0; i < 12; i++) begin
      slow <= ~i[0];
      wr(ADCSC_OFF_MODE, {i[0], 3'b011, 4'(i + 4)});
      wr(ADCSC_OFF_START, 8'h80);
      t0 = $time;
      chk({27'h0, ana.mux_en, ana.mux_sel}, {27'h0, 1'b1, 4'(i)});
      rc(ADCSC_OFF_START, 8'hff);
      wait_done(i[0] ? 32 : 63);
      rc(ADCSC_OFF_RESULT, level[i]);
      rc(ADCSC_OFF_START, 8'h7f);
      wr(ADCSC_OFF_IRQ, 8'h02);
    end
    repeat (50) @(posedge sys_clk);
    rc(ADCSC_OFF_RESULT, level[11]);
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    rc(ADCSC_OFF_RESULT, level[11]);
    rc(ADCSC_OFF_MODE, 8'h30);
    wr(ADCSC_OFF_IRQ, 8'h02);
    slow <= 1'b1;
    wr(ADCSC_OFF_MODE, 8'h34);
    wr(ADCSC_OFF_START, 8'h80);
    t0 = $time;
    repeat (20) @(posedge sys_clk);
    wr(ADCSC_OFF_START, 8'h80);
    wait_done(63);
    rc(ADCSC_OFF_RESULT, level[0]);
    wr(ADCSC_OFF_IRQ, 8'h02);
    wr(ADCSC_OFF_MODE, 8'h35);
    wr(ADCSC_OFF_START, 8'h80);
    // abort only after sampling, so the sample phase is never cut short
    repeat (20) @(posedge sys_clk);
    wr(ADCSC_OFF_START, 8'h00);
    rc(ADCSC_OFF_START, 8'h7f);
    rc(ADCSC_OFF_RESULT, level[0]);
    rc(ADCSC_OFF_IRQ, 8'h03);
    wr(ADCSC_OFF_IRQ, 8'h00);
    // case bits: pin function, trigger enable, rising polarity, new pin level, start expected
    for (int k = 0; k < 5; k++) begin
      tc = tcase[k];
      wr(ADCSC_OFF_MODE, 8'hb4);
      pin <= ~tc[1];
      repeat (3) @(posedge sys_clk);
      wr(ADCSC_OFF_IRQ, {4'h0, tc[2], tc[4], 2'b00});
      wr(ADCSC_OFF_MODE, {1'b1, tc[3], 2'b11, 4'h4});
      pin <= tc[1];
      repeat (3) @(posedge sys_clk);
      rc(ADCSC_OFF_START, tc[0] ? 8'hff : 8'h7f);
      repeat (40) @(posedge sys_clk);
    end
    results();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    results();
  end
endmodule : adcsc_tb_top
